/* tpu_timer_unit.sv */
// Timer/PWM unit: prescaler, two 8-bit reload timers, 16-bit clock timer,
// 4-bit LCD divider, timer pin control and timer request flags.
// Assumes an APB master on pclk; oscillator and trigger pins are asynchronous.
//
// Behaviour
// RULE1 - First timer: 8-bit down counter, reload, read
// RULE2 - First timer source field and run bit
// RULE3 - First timer divides n+1, flags, reloads
// RULE4 - Trigger edge arms first timer when enabled
// RULE5 - Armed latch cleared by disable, reset, autostop
// RULE6 - Autostop: underflow cuts count source when synchronised
// RULE7 - Second timer: counter, low/high reloads, commands
// RULE8 - Second timer source bit and run bit
// RULE9 - Second timer divides n+1, flags, reloads low
// RULE10 - Output select alternates low/high reload forming PWM
// RULE11 - High extension adds half source period
// RULE12 - Software keeps high reload nonzero with extension
// RULE13 - Auto-control toggles PWM validity per first underflow
// RULE14 - Second timer stopped in high phase finishes
// RULE15 - Third timer: 16-bit, ratio, source, run, flag
// RULE16 - Third timer stop sets all ones
// RULE17 - Third timer underflow wakes from clock mode
// RULE18 - Third timer bit four feeds LCD divider
// RULE19 - LCD divider: 4-bit, write-only load, n+1
// RULE20 - LCD divider underflow halved gives LCD clock
// RULE21 - Pin input counting edge; pin output released
// RULE22 - Flags cleared by interrupt or skip
// RULE23 - Prescaler divides instruction clock by n+1
// RULE24 - Reset clears controls; third counter all ones
`timescale 1ns/1ps
module tpu_timer_unit #(
  parameter int INSTR_DIV = tpu_pkg::INSTR_DIV_DEFAULT
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        xin_pin,
  input  wire logic        xcin_pin,
  input  wire logic        ext_trigger_pin,
  input  wire logic        timer_io_pin_in,
  output logic             timer_io_pin_out,
  output logic             timer_io_pin_oe,
  input  wire logic        clock_mode,
  input  wire logic [2:0]  irq_taken,
  output logic             first_timer_irq_flag,
  output logic             second_timer_irq_flag,
  output logic             third_timer_irq_flag,
  output logic             wake_up,
  output logic             lcd_clock
);

  if (INSTR_DIV < 1 || INSTR_DIV > 256) begin : g_bad_div
    $error("INSTR_DIV must lie in 1..256");
  end

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_DIV - 1);

  tpu_pkg::tpu_state_s s;
  tpu_pkg::tpu_state_s next_s;

  always_comb begin
    logic        instr_tick;
    logic        xin_rise;
    logic        xin_fall;
    logic        xcin_rise;
    logic        pin_edge;
    logic        ext_valid;
    logic        presc_pulse;
    logic        full2;
    logic        half2;
    logic        cnt_p2;
    logic        oth_p2;
    logic        t2_tick;
    logic        t2_uf;
    logic        pwm_mode;
    logic [15:0] t3_mask;
    logic        t3_src;
    logic        t3_tick;
    logic        t3_uf;
    logic        lcd_t3;
    logic        t1_src;
    logic        t1_tick;
    logic        t1_uf;
    logic        lcd_tick;
    logic        hit;
    logic [31:0] rd;
    logic        wr;
    instr_tick = 1'b0;
    xin_rise   = 1'b0;
    xin_fall   = 1'b0;
    xcin_rise  = 1'b0;
    pin_edge   = 1'b0;
    ext_valid  = 1'b0;
    presc_pulse = 1'b0;
    full2 = 1'b0;
    half2 = 1'b0;
    cnt_p2 = 1'b0;
    oth_p2 = 1'b0;
    t2_tick = 1'b0;
    t2_uf = 1'b0;
    pwm_mode = 1'b0;
    t3_mask = tpu_pkg::T3_MASK_3;
    t3_src = 1'b0;
    t3_tick = 1'b0;
    t3_uf = 1'b0;
    lcd_t3 = 1'b0;
    t1_src = 1'b0;
    t1_tick = 1'b0;
    t1_uf = 1'b0;
    lcd_tick = 1'b0;
    hit = 1'b0;
    rd = 32'h0000_0000;
    wr = 1'b0;
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.wake = 1'b0;

    // Pin synchronisers; bit 2 is the previous synchronised level
    next_s.xin_sync  = {s.xin_sync[1:0], xin_pin};
    next_s.xcin_sync = {s.xcin_sync[1:0], xcin_pin};
    next_s.pin_sync  = {s.pin_sync[1:0], timer_io_pin_in};
    next_s.ext_sync  = {s.ext_sync[1:0], ext_trigger_pin};
    xin_rise  = s.xin_sync[1] & ~s.xin_sync[2];
    xin_fall  = ~s.xin_sync[1] & s.xin_sync[2];
    xcin_rise = s.xcin_sync[1] & ~s.xcin_sync[2];
    pin_edge  = s.w4.edge_rise ? (s.pin_sync[1] & ~s.pin_sync[2])
                               : (~s.pin_sync[1] & s.pin_sync[2]); // see RULE21
    ext_valid = s.ext_edge_rise ? (s.ext_sync[1] & ~s.ext_sync[2])
                                : (~s.ext_sync[1] & s.ext_sync[2]);

    // Instruction clock enable
    instr_tick = (s.instr_cnt == INSTR_LAST);
    next_s.instr_cnt = instr_tick ? 8'h00 : s.instr_cnt + 8'h01;

    // Prescaler
    presc_pulse = s.presc_run & instr_tick & (s.presc_cnt == 8'h00);
    if (!s.presc_run) begin
      next_s.presc_cnt = s.presc_reload;
    end else if (instr_tick) begin
      next_s.presc_cnt = (s.presc_cnt == 8'h00) ? s.presc_reload
                                                : s.presc_cnt - 8'h01; // see RULE23
    end

    // Third timer
    case (s.w3.ratio)
      2'h0:    t3_mask = tpu_pkg::T3_MASK_0;
      2'h1:    t3_mask = tpu_pkg::T3_MASK_1;
      2'h2:    t3_mask = tpu_pkg::T3_MASK_2;
      default: t3_mask = tpu_pkg::T3_MASK_3;
    endcase
    t3_src  = s.w3.src ? presc_pulse : xcin_rise;
    t3_tick = s.w3.run & t3_src; // see RULE15
    t3_uf   = t3_tick & ((s.t3_cnt & t3_mask) == 16'h0000);
    lcd_t3  = t3_tick & (s.t3_cnt[4:0] == 5'h00); // see RULE18
    if (!s.w3.run) begin
      next_s.t3_cnt = tpu_pkg::T3_RESET; // see RULE16
    end else if (t3_tick) begin
      next_s.t3_cnt = s.t3_cnt - 16'h0001;
    end
    next_s.wake = t3_uf & clock_mode; // see RULE17

    // Second timer; half pulses give the half-period extension
    if (presc_pulse) begin
      next_s.p2_tog = ~s.p2_tog;
    end
    full2  = s.w2.src ? (presc_pulse & s.p2_tog) : xin_rise; // see RULE8
    half2  = s.w2.src ? (presc_pulse & ~s.p2_tog) : xin_fall;
    cnt_p2 = s.phase_half ? half2 : full2;
    oth_p2 = s.phase_half ? full2 : half2;
    pwm_mode = s.w2.out_en;
    t2_tick = (s.w2.run | s.t2_hold) & cnt_p2 & ~s.ext_wait;
    t2_uf   = t2_tick & (s.t2_cnt == 8'h00);
    // A stop in the high phase lets the count run to its underflow
    next_s.t2_hold = s.w2.run | (s.t2_hold & s.pwm & ~t2_uf); // see RULE14
    if (t2_uf) begin
      if (pwm_mode && !s.pwm) begin
        next_s.t2_cnt = s.t2_high; // see RULE10
        next_s.pwm = 1'b1;
      end else if (pwm_mode && s.w2.high_ext) begin
        next_s.ext_wait = 1'b1; // see RULE11
      end else begin
        next_s.t2_cnt = s.t2_low; // see RULE9
        next_s.pwm = 1'b0;
      end
    end else if (t2_tick) begin
      next_s.t2_cnt = s.t2_cnt - 8'h01;
    end
    // Extension ends on the opposite edge, so the phase of counting flips
    if (s.ext_wait && oth_p2) begin
      next_s.ext_wait = 1'b0;
      next_s.t2_cnt = s.t2_low;
      next_s.pwm = 1'b0;
      next_s.phase_half = ~s.phase_half; // see RULE11
    end
    if (!pwm_mode) begin
      next_s.pwm = 1'b0;
      next_s.ext_wait = 1'b0;
    end
    next_s.pwm_prev = s.pwm;

    // First timer
    case (s.w1.src)
      tpu_pkg::SRC1_PWM:   t1_src = s.pwm & ~s.pwm_prev;
      tpu_pkg::SRC1_PRESC: t1_src = presc_pulse;
      tpu_pkg::SRC1_T3UF:  t1_src = t3_uf;
      default:             t1_src = pin_edge; // see RULE21
    endcase
    t1_tick = s.w1.run & (~s.sync_en | s.sync_latch) & t1_src; // see RULE2, RULE4
    t1_uf = t1_tick & (s.t1_cnt == 8'h00);
    if (t1_uf) begin
      next_s.t1_cnt = s.t1_reload; // see RULE3
    end else if (t1_tick) begin
      next_s.t1_cnt = s.t1_cnt - 8'h01; // see RULE1
    end
    if (!s.sync_en) begin
      next_s.sync_latch = 1'b0; // see RULE5
    end else if (t1_uf && s.w1.auto_stop) begin
      next_s.sync_latch = 1'b0; // see RULE6
    end else if (ext_valid) begin
      next_s.sync_latch = 1'b1; // see RULE4
    end
    if (!s.w1.run) begin
      next_s.out_valid = 1'b1; // see RULE13
    end else if (s.w4.auto_ctl && t1_uf) begin
      next_s.out_valid = ~s.out_valid; // see RULE13
    end

    // LCD divider; system clock source is every pclk cycle
    lcd_tick = s.w4.run & (s.w4.src | lcd_t3);
    if (lcd_tick) begin
      if (s.lcd_cnt == 4'h0) begin
        next_s.lcd_cnt = s.lcd_reload; // see RULE19
        next_s.lcd_clk = ~s.lcd_clk; // see RULE20
      end else begin
        next_s.lcd_cnt = s.lcd_cnt - 4'h1;
      end
    end

    // APB read answer one cycle into the access phase
    case (paddr)
      tpu_pkg::ADDR_CTRL1:      begin hit = 1'b1; rd = {28'h000_0000, s.w1}; end
      tpu_pkg::ADDR_CTRL2:      begin hit = 1'b1; rd = {28'h000_0000, s.w2}; end
      tpu_pkg::ADDR_CTRL3:      begin hit = 1'b1; rd = {28'h000_0000, s.w3}; end
      tpu_pkg::ADDR_CTRL4:      begin hit = 1'b1; rd = {28'h000_0000, s.w4}; end
      tpu_pkg::ADDR_EXT_CTRL:   begin
        hit = 1'b1;
        rd = {30'h0000_0000, s.ext_edge_rise, s.sync_en};
      end
      tpu_pkg::ADDR_PRESCALER:  begin
        hit = 1'b1;
        rd = {23'h00_0000, s.presc_run, s.presc_reload};
      end
      tpu_pkg::ADDR_T1_LOAD:    begin hit = 1'b1; rd = {24'h00_0000, s.t1_cnt}; end
      tpu_pkg::ADDR_T1_RELOAD:  begin hit = 1'b1; rd = {24'h00_0000, s.t1_reload}; end
      tpu_pkg::ADDR_T2_LOAD:    begin hit = 1'b1; rd = {24'h00_0000, s.t2_cnt}; end
      tpu_pkg::ADDR_T2_HIGH:    begin hit = 1'b1; rd = {24'h00_0000, s.t2_high}; end
      tpu_pkg::ADDR_T2_REL_LOW: begin hit = 1'b1; rd = {24'h00_0000, s.t2_low}; end
      tpu_pkg::ADDR_LCD_LOAD:   begin hit = 1'b1; rd = 32'h0000_0000; end
      tpu_pkg::ADDR_FLAGS:      begin hit = 1'b1; rd = {29'h0000_0000, s.flags}; end
      tpu_pkg::ADDR_STATUS:     begin
        hit = 1'b1;
        rd = {27'h000_0000, s.ext_wait, s.pwm, s.lcd_clk, s.out_valid, s.sync_latch};
      end
      tpu_pkg::ADDR_T3_COUNT:   begin hit = 1'b1; rd = {16'h0000, s.t3_cnt}; end
      default:                  begin hit = 1'b0; rd = 32'h0000_0000; end
    endcase
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      next_s.pslverr = ~hit;
      next_s.prdata = pwrite ? 32'h0000_0000 : rd;
    end

    // Flags: clear first so a same-cycle underflow still sets
    wr = psel & penable & pwrite & s.pready & hit;
    next_s.flags = s.flags & ~irq_taken; // see RULE22
    if (wr && paddr == tpu_pkg::ADDR_FLAGS) begin
      next_s.flags = next_s.flags & ~pwdata[2:0]; // see RULE22
    end
    next_s.flags = next_s.flags | {t3_uf, t2_uf, t1_uf}; // see RULE3, RULE9, RULE15

    // Commands; loads win over counting, so stop the timer first
    if (wr) begin
      case (paddr)
        tpu_pkg::ADDR_CTRL1:      next_s.w1 = pwdata[3:0];
        tpu_pkg::ADDR_CTRL2:      next_s.w2 = pwdata[3:0];
        tpu_pkg::ADDR_CTRL3:      next_s.w3 = pwdata[3:0];
        tpu_pkg::ADDR_CTRL4:      next_s.w4 = pwdata[3:0];
        tpu_pkg::ADDR_EXT_CTRL:   begin
          next_s.sync_en = pwdata[tpu_pkg::EXT_SYNC_BIT];
          next_s.ext_edge_rise = pwdata[tpu_pkg::EXT_EDGE_BIT];
        end
        tpu_pkg::ADDR_PRESCALER:  begin
          next_s.presc_reload = pwdata[7:0];
          next_s.presc_run = pwdata[tpu_pkg::PRESC_RUN_BIT];
        end
        tpu_pkg::ADDR_T1_LOAD:    begin
          next_s.t1_cnt = pwdata[7:0]; // see RULE1
          next_s.t1_reload = pwdata[7:0];
        end
        tpu_pkg::ADDR_T1_RELOAD:  next_s.t1_reload = pwdata[7:0]; // see RULE1
        tpu_pkg::ADDR_T2_LOAD:    begin
          next_s.t2_cnt = pwdata[7:0]; // see RULE7
          next_s.t2_low = pwdata[7:0];
        end
        tpu_pkg::ADDR_T2_HIGH:    next_s.t2_high = pwdata[7:0]; // see RULE7
        tpu_pkg::ADDR_T2_REL_LOW: next_s.t2_cnt = s.t2_low; // see RULE7
        tpu_pkg::ADDR_LCD_LOAD:   begin
          next_s.lcd_cnt = pwdata[3:0]; // see RULE19
          next_s.lcd_reload = pwdata[3:0];
        end
        default:                  next_s.lcd_cnt = next_s.lcd_cnt;
      endcase
    end

    // Pin released while it is the first timer's input
    next_s.pin_oe  = (next_s.w1.src != tpu_pkg::SRC1_PIN) & next_s.w2.out_en; // see RULE21
    next_s.pin_out = next_s.pwm & next_s.out_valid; // see RULE10, RULE13
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= tpu_pkg::STATE_RESET; // see RULE24
    end else begin
      s <= next_s;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign timer_io_pin_out      = s.pin_out;
  assign timer_io_pin_oe       = s.pin_oe;
  assign first_timer_irq_flag  = s.flags[0];
  assign second_timer_irq_flag = s.flags[1];
  assign third_timer_irq_flag  = s.flags[2];
  assign wake_up               = s.wake;
  assign lcd_clock             = s.lcd_clk;

endmodule : tpu_timer_unit

/* tpu_pkg.sv */
// Constants, register map and state types of the timer/PWM unit.
// Assumes an APB slave with byte addresses on the low eight bits of paddr.
package tpu_pkg;

  localparam int ADDR_W = 8;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL1      = 8'h00;
  localparam logic [7:0] ADDR_CTRL2      = 8'h04;
  localparam logic [7:0] ADDR_CTRL3      = 8'h08;
  localparam logic [7:0] ADDR_CTRL4      = 8'h0C;
  localparam logic [7:0] ADDR_EXT_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_PRESCALER  = 8'h14;
  localparam logic [7:0] ADDR_T1_LOAD    = 8'h18;
  localparam logic [7:0] ADDR_T1_RELOAD  = 8'h1C;
  localparam logic [7:0] ADDR_T2_LOAD    = 8'h20;
  localparam logic [7:0] ADDR_T2_HIGH    = 8'h24;
  localparam logic [7:0] ADDR_T2_REL_LOW = 8'h28;
  localparam logic [7:0] ADDR_LCD_LOAD   = 8'h2C;
  localparam logic [7:0] ADDR_FLAGS      = 8'h30;
  localparam logic [7:0] ADDR_STATUS     = 8'h34;
  localparam logic [7:0] ADDR_T3_COUNT   = 8'h38;

  // Field positions
  localparam int PRESC_RUN_BIT = 8;
  localparam int EXT_SYNC_BIT  = 0;
  localparam int EXT_EDGE_BIT  = 1;

  // First timer count source codes
  localparam logic [1:0] SRC1_PWM   = 2'h0;
  localparam logic [1:0] SRC1_PRESC = 2'h1;
  localparam logic [1:0] SRC1_T3UF  = 2'h2;
  localparam logic [1:0] SRC1_PIN   = 2'h3;

  // Third timer ratio masks: 8192, 16384, 32768, 65536 counts
  localparam logic [15:0] T3_MASK_0 = 16'h1FFF;
  localparam logic [15:0] T3_MASK_1 = 16'h3FFF;
  localparam logic [15:0] T3_MASK_2 = 16'h7FFF;
  localparam logic [15:0] T3_MASK_3 = 16'hFFFF;
  localparam logic [15:0] T3_RESET  = 16'hFFFF;

  localparam int INSTR_DIV_DEFAULT = 4;

  typedef struct packed {
    logic       auto_stop;
    logic       run;
    logic [1:0] src;
  } tpu_ctl1_s;

  typedef struct packed {
    logic out_en;
    logic high_ext;
    logic run;
    logic src;
  } tpu_ctl2_s;

  typedef struct packed {
    logic       src;
    logic       run;
    logic [1:0] ratio;
  } tpu_ctl3_s;

  typedef struct packed {
    logic run;
    logic src;
    logic auto_ctl;
    logic edge_rise;
  } tpu_ctl4_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  xin_sync;
    logic [2:0]  xcin_sync;
    logic [2:0]  pin_sync;
    logic [2:0]  ext_sync;
    logic [7:0]  instr_cnt;
    tpu_ctl1_s   w1;
    tpu_ctl2_s   w2;
    tpu_ctl3_s   w3;
    tpu_ctl4_s   w4;
    logic        sync_en;
    logic        ext_edge_rise;
    logic        presc_run;
    logic [7:0]  presc_cnt;
    logic [7:0]  presc_reload;
    logic [7:0]  t1_cnt;
    logic [7:0]  t1_reload;
    logic        sync_latch;
    logic        out_valid;
    logic        p2_tog;
    logic [7:0]  t2_cnt;
    logic [7:0]  t2_low;
    logic [7:0]  t2_high;
    logic        t2_hold;
    logic        pwm;
    logic        pwm_prev;
    logic        ext_wait;
    logic        phase_half;
    logic [15:0] t3_cnt;
    logic [3:0]  lcd_cnt;
    logic [3:0]  lcd_reload;
    logic        lcd_clk;
    logic [2:0]  flags;
    logic        wake;
    logic        pin_out;
    logic        pin_oe;
  } tpu_state_s;

  localparam tpu_state_s STATE_RESET = '{t3_cnt: T3_RESET, out_valid: 1'b1, default: '0};

endpackage : tpu_pkg

/* tpu_timer_unit_properties.sv */
// Checker for the timer unit: bus handshake, timer flags and wake pulse.
// Assumes it is bound to tpu_timer_unit and sees only that module's ports.
`timescale 1ns/1ps
module tpu_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        clock_mode,
  input wire logic [2:0]  irq_taken,
  input wire logic        first_timer_irq_flag,
  input wire logic        second_timer_irq_flag,
  input wire logic        third_timer_irq_flag,
  input wire logic        wake_up
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic       acc;
  logic       mapped;
  logic [2:0] clr;
  // Flag clears come from a taken interrupt or a completed flag write
  assign acc    = psel && penable;
  assign mapped = (paddr <= tpu_pkg::ADDR_T3_COUNT) && (paddr[1:0] == 2'h0);
  assign clr    = irq_taken | ({3{acc && pwrite && pready && paddr == tpu_pkg::ADDR_FLAGS}}
                  & pwdata[2:0]);

  sequence acc_start;
    acc && !pready;
  endsequence
  sequence one_pulse;
    pready ##1 !pready;
  endsequence

  a_ready_two_cycle: assert property (acc_start |=> one_pulse)
    else $error("pready not one pulse after access");
  a_ready_needs_req: assert property (pready |-> $past(acc))
    else $error("pready without access");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access with pslverr");
  a_wake_in_mode: assert property (wake_up |-> $past(clock_mode))
    else $error("wake pulse outside clock mode");
  a_wake_sets_flag: assert property (wake_up |-> ##[0:1] third_timer_irq_flag)
    else $error("wake pulse without third flag");
  a_wake_one_cycle: assert property (wake_up |=> !wake_up)
    else $error("wake pulse longer than one cycle");
  a_first_flag_cause: assert property ($fell(first_timer_irq_flag) |-> $past(clr[0]))
    else $error("first flag dropped without clear");
  a_second_flag_cause: assert property (
    $past(second_timer_irq_flag) && !second_timer_irq_flag |-> $past(clr[1]))
    else $error("second flag dropped without clear");
  // A clear sampled on this edge takes the flag down on the next one
  a_third_flag_cause: assert property (
    third_timer_irq_flag && !clr[2] |=> third_timer_irq_flag)
    else $error("third flag dropped without clear");
endmodule : tpu_checker

/* test_tpu_timer_unit.sv */
// Self-checking bench for the timer unit, driven over APB.
// Assumes tpu_pkg, tpu_timer_unit and tpu_checker are compiled first.
`timescale 1ns/1ps
module test_tpu_timer_unit;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  pins;
  logic        pin_out;
  logic        pin_oe;
  logic        clock_mode;
  logic [2:0]  irq_taken;
  logic [2:0]  flags;
  logic        wake_up;
  logic        wake_seen;
  logic        lcd_clock;
  int          mismatches;
  int          comparisons;
  int          cycles;

  // Instruction clock equals pclk so the third timer period stays short
  tpu_timer_unit #(.INSTR_DIV(1)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xin_pin(pins[0]), .xcin_pin(1'b0), .ext_trigger_pin(pins[1]),
    .timer_io_pin_in(pins[2]), .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe),
    .clock_mode(clock_mode), .irq_taken(irq_taken), .first_timer_irq_flag(flags[0]),
    .second_timer_irq_flag(flags[1]), .third_timer_irq_flag(flags[2]),
    .wake_up(wake_up), .lcd_clock(lcd_clock)
  );

  always #4 pclk = ~pclk;

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (wake_up === 1'b1) begin
      wake_seen <= 1'b1;
    end
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", w, x, g);
    end
  endtask : chk

  // Holds the request until pready is sampled high, then releases
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                    input string w);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(w, x, q & m);
  endtask : rd

  // Pulses are long enough to pass the three-edge pin synchroniser
  task automatic pulse(input int i, input int k);
    repeat (k) begin
      pins[i] <= 1'b1;
      repeat (6) @(posedge pclk);
      pins[i] <= 1'b0;
      repeat (6) @(posedge pclk);
    end
  endtask : pulse

  task automatic t_reset;
    logic [7:0]  a[9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h30};
    logic [31:0] q;
    logic        e;
    foreach (a[i]) rd(a[i], 32'hFFFF_FFFF, 32'h0000_0000, "reset_reg");
    wr(tpu_pkg::ADDR_T3_COUNT, 32'h0000_0000);
    rd(tpu_pkg::ADDR_T3_COUNT, 32'hFFFF_FFFF, 32'h0000_FFFF, "third_reset");
    apb(1'b0, 8'h3C, 32'h0000_0000, q, e);
    chk("unmapped_err", 32'h0000_0001, e);
    chk("unmapped_data", 32'h0000_0000, q);
  endtask : t_reset

  task automatic t_first;
    wr(tpu_pkg::ADDR_CTRL4, 32'h0000_0001);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0008);
    wr(tpu_pkg::ADDR_T1_LOAD, 32'h0000_0003);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0007);
    pulse(2, 2);
    chk("pin_released", 32'h0000_0000, pin_oe);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0003);
    rd(tpu_pkg::ADDR_T1_LOAD, 32'h0000_00FF, 32'h0000_0001, "first_count");
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0007);
    pulse(2, 2);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0003);
    rd(tpu_pkg::ADDR_T1_LOAD, 32'h0000_00FF, 32'h0000_0003, "first_reload");
    chk("first_flag", 32'h0000_0001, flags[0]);
    irq_taken <= 3'h1;
    @(posedge pclk);
    irq_taken <= 3'h0;
    repeat (2) @(posedge pclk);
    chk("first_flag_taken", 32'h0000_0000, flags[0]);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("pin_driven", 32'h0000_0001, pin_oe);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0000);
  endtask : t_first

  task automatic t_second;
    wr(tpu_pkg::ADDR_T2_LOAD, 32'h0000_0001);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0002);
    pulse(0, 1);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0000);
    rd(tpu_pkg::ADDR_T2_LOAD, 32'h0000_00FF, 32'h0000_0000, "second_count");
    wr(tpu_pkg::ADDR_T2_REL_LOW, 32'h0000_0000);
    rd(tpu_pkg::ADDR_T2_LOAD, 32'h0000_00FF, 32'h0000_0001, "second_from_low");
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0002);
    pulse(0, 2);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0000);
    rd(tpu_pkg::ADDR_T2_LOAD, 32'h0000_00FF, 32'h0000_0001, "second_reload");
    chk("second_flag", 32'h0000_0001, flags[1]);
    wr(tpu_pkg::ADDR_FLAGS, 32'h0000_0002);
    chk("second_flag_skip", 32'h0000_0000, flags[1]);
  endtask : t_second

  // Without the extension the last high underflow would drop the pin within 6 cycles
  task automatic t_pwm;
    wr(tpu_pkg::ADDR_T2_HIGH, 32'h0000_0001);
    wr(tpu_pkg::ADDR_T2_LOAD, 32'h0000_0001);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_000A);
    pulse(0, 2);
    chk("pwm_high", 32'h0000_0001, pin_out);
    pulse(0, 2);
    chk("pwm_low", 32'h0000_0000, pin_out);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_000E);
    pulse(0, 3);
    pins[0] <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("pwm_extended", 32'h0000_0001, pin_out);
    pins[0] <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("pwm_ext_end", 32'h0000_0000, pin_out);
    wr(tpu_pkg::ADDR_CTRL2, 32'h0000_0000);
  endtask : t_pwm

  task automatic t_sync;
    wr(tpu_pkg::ADDR_EXT_CTRL, 32'h0000_0003);
    wr(tpu_pkg::ADDR_T1_LOAD, 32'h0000_0001);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_000F);
    pulse(2, 2);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_000B);
    rd(tpu_pkg::ADDR_T1_LOAD, 32'h0000_00FF, 32'h0000_0001, "unarmed_count");
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_000F);
    pulse(1, 1);
    rd(tpu_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0001, "sync_armed");
    pulse(2, 3);
    rd(tpu_pkg::ADDR_STATUS, 32'h0000_0001, 32'h0000_0000, "sync_cleared");
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_000B);
    rd(tpu_pkg::ADDR_T1_LOAD, 32'h0000_00FF, 32'h0000_0001, "auto_stopped");
    wr(tpu_pkg::ADDR_FLAGS, 32'h0000_0001);
    wr(tpu_pkg::ADDR_EXT_CTRL, 32'h0000_0000);
    wr(tpu_pkg::ADDR_CTRL1, 32'h0000_0000);
  endtask : t_sync

  task automatic t_third;
    int n;
    n = 0;
    wr(tpu_pkg::ADDR_PRESCALER, 32'h0000_0100);
    clock_mode <= 1'b1;
    wr(tpu_pkg::ADDR_CTRL3, 32'h0000_000C);
    while (flags[2] !== 1'b1 && n < 10000) begin
      @(posedge pclk);
      n++;
    end
    chk("third_period", 32'h0000_0001, n > 8150 && n < 8200);
    repeat (2) @(posedge pclk);
    chk("wake_seen", 32'h0000_0001, wake_seen);
    clock_mode <= 1'b0;
    wr(tpu_pkg::ADDR_CTRL3, 32'h0000_0008);
    rd(tpu_pkg::ADDR_T3_COUNT, 32'hFFFF_FFFF, 32'h0000_FFFF, "third_stopped");
    wr(tpu_pkg::ADDR_FLAGS, 32'h0000_0004);
  endtask : t_third

  task automatic t_lcd;
    logic l;
    int   n;
    wr(tpu_pkg::ADDR_LCD_LOAD, 32'h0000_0003);
    wr(tpu_pkg::ADDR_CTRL4, 32'h0000_000D);
    rd(tpu_pkg::ADDR_LCD_LOAD, 32'hFFFF_FFFF, 32'h0000_0000, "lcd_write_only");
    repeat (2) begin
      l = lcd_clock;
      n = 0;
      while (lcd_clock === l && n < 100) begin
        @(posedge pclk);
        n++;
      end
    end
    chk("lcd_half_period", 32'h0000_0004, n);
    wr(tpu_pkg::ADDR_CTRL4, 32'h0000_0000);
  endtask : t_lcd

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    pins        = 3'h0;
    clock_mode  = 1'b0;
    irq_taken   = 3'h0;
    wake_seen   = 1'b0;
    mismatches  = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_first();
    t_second();
    t_pwm();
    t_sync();
    t_third();
    t_lcd();
    end_of_test();
  end
endmodule : test_tpu_timer_unit

bind tpu_timer_unit tpu_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .clock_mode(clock_mode), .irq_taken(irq_taken),
  .first_timer_irq_flag(first_timer_irq_flag), .second_timer_irq_flag(second_timer_irq_flag),
  .third_timer_irq_flag(third_timer_irq_flag), .wake_up(wake_up)
);
